/* File: sccr_regs.sv */
// clock input, clock generator, general logic and pixel core register bank
`include "sccr_consts.svh"

module sccr_regs
    import sccr_pkg::*;
(
    input  wire logic        i_mclk,
    input  wire logic        i_nrst,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    input  wire logic [8:0]  i_addr,
    input  wire logic [15:0] i_wdata,
    input  wire logic        i_synth_lock,
    output logic      [15:0] o_rdata,
    output sccr_ctrl_t       o_ctrl
);

    sccr_req_t   req;
    sccr_state_t st;
    sccr_state_t next_st;

    assign req = '{wr: i_wr, rd: i_rd, addr: i_addr, wdata: i_wdata};

    function automatic logic [15:0] upd(input logic [15:0] cur, input logic [15:0] mask,
                                        input logic hit, input logic [15:0] wdata);
        upd = hit ? (wdata & mask) : cur;
    endfunction : upd

    // write strobe aimed at one register address
    function automatic logic wr_hit(input sccr_req_t r, input logic [8:0] a);
        wr_hit = r.wr && r.addr == a;
    endfunction : wr_hit

    // addresses that the read decoder answers
    function automatic logic is_mapped(input logic [8:0] a);
        case (a)
            `SCCR_ADDR_SYN_PWR,
            `SCCR_ADDR_IO_CFG,
            `SCCR_ADDR_LOCK_STS,
            `SCCR_ADDR_LOCK_RSV_A,
            `SCCR_ADDR_LOCK_RSV_B,
            `SCCR_ADDR_CGEN_CFG,
            `SCCR_ADDR_GEN_CFG,
            `SCCR_ADDR_CORE_CFG: is_mapped = 1'b1;
            default:             is_mapped = 1'b0;
        endcase
    endfunction : is_mapped

    always_comb begin
        next_st = st;
        // lock pin is asynchronous to the bus clock
        next_st.lock_m = i_synth_lock;
        next_st.lock_s = st.lock_m;
        next_st.syn_pwr  = upd(st.syn_pwr, `SCCR_MASK_SYN_PWR,
                               wr_hit(req, `SCCR_ADDR_SYN_PWR), req.wdata);
        next_st.io_cfg   = upd(st.io_cfg, `SCCR_MASK_IO_CFG,
                               wr_hit(req, `SCCR_ADDR_IO_CFG), req.wdata);
        next_st.rsv_a    = upd(st.rsv_a, `SCCR_MASK_LOCK_RSV_A,
                               wr_hit(req, `SCCR_ADDR_LOCK_RSV_A), req.wdata);
        next_st.rsv_b    = upd(st.rsv_b, `SCCR_MASK_LOCK_RSV_B,
                               wr_hit(req, `SCCR_ADDR_LOCK_RSV_B), req.wdata);
        next_st.cgen_cfg = upd(st.cgen_cfg, `SCCR_MASK_CGEN_CFG,
                               wr_hit(req, `SCCR_ADDR_CGEN_CFG), req.wdata);
        next_st.gen_cfg  = upd(st.gen_cfg, `SCCR_MASK_GEN_CFG,
                               wr_hit(req, `SCCR_ADDR_GEN_CFG), req.wdata);
        next_st.core_cfg = upd(st.core_cfg, `SCCR_MASK_CORE_CFG,
                               wr_hit(req, `SCCR_ADDR_CORE_CFG), req.wdata);
        next_st.rdata = 16'h0000;
        if (req.rd) begin
            unique case (req.addr)
                `SCCR_ADDR_SYN_PWR:    next_st.rdata = st.syn_pwr;
                `SCCR_ADDR_IO_CFG:     next_st.rdata = st.io_cfg;
                `SCCR_ADDR_LOCK_STS:   next_st.rdata = {15'h0000, st.lock_s};
                `SCCR_ADDR_LOCK_RSV_A: next_st.rdata = st.rsv_a;
                `SCCR_ADDR_LOCK_RSV_B: next_st.rdata = st.rsv_b;
                `SCCR_ADDR_CGEN_CFG:   next_st.rdata = st.cgen_cfg;
                `SCCR_ADDR_GEN_CFG:    next_st.rdata = st.gen_cfg;
                `SCCR_ADDR_CORE_CFG:   next_st.rdata = st.core_cfg;
                default:               next_st.rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            st.syn_pwr  <= `SCCR_RST_SYN_PWR;
            st.io_cfg   <= `SCCR_RST_IO_CFG;
            st.rsv_a    <= `SCCR_RST_LOCK_RSV_A;
            st.rsv_b    <= `SCCR_RST_LOCK_RSV_B;
            st.cgen_cfg <= `SCCR_RST_CGEN_CFG;
            st.gen_cfg  <= `SCCR_RST_GEN_CFG;
            st.core_cfg <= `SCCR_RST_CORE_CFG;
            st.rdata    <= 16'h0000;
            st.lock_m   <= 1'b0;
            st.lock_s   <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    assign o_rdata = st.rdata;

    always_comb begin
        o_ctrl.synth_run    = st.syn_pwr[`SCCR_BIT_SYN_RUN];
        o_ctrl.synth_en     = st.syn_pwr[`SCCR_BIT_SYN_EN];
        o_ctrl.synth_bypass = st.syn_pwr[`SCCR_BIT_SYN_BYPASS];
        o_ctrl.clkin_pwr    = st.io_cfg[`SCCR_BIT_CLKIN_PWR];
        o_ctrl.ana_clk_en   = st.cgen_cfg[`SCCR_BIT_ANA_CLK_EN];
        o_ctrl.log_clk_en   = st.cgen_cfg[`SCCR_BIT_LOG_CLK_EN];
        o_ctrl.sel_synth    = st.cgen_cfg[`SCCR_BIT_SEL_SYNTH];
        o_ctrl.adc_8bit     = st.cgen_cfg[`SCCR_BIT_ADC_8BIT];
        o_ctrl.gen_en       = st.gen_cfg[`SCCR_BIT_GEN_EN];
        o_ctrl.core_pwr     = st.core_cfg[`SCCR_BIT_CORE_PWR];
        o_ctrl.mux_pwr      = st.core_cfg[`SCCR_BIT_MUX_PWR];
        o_ctrl.colbias_en   = st.core_cfg[`SCCR_BIT_COLBIAS_EN];
    end

    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_nrst);

    chk_clkin_pwr_wr: assert property (
        i_wr && i_addr == `SCCR_ADDR_IO_CFG |=> o_ctrl.clkin_pwr == $past(i_wdata[0]))
        else $error("clock input power bit did not follow write");
    chk_ana_clk_wr: assert property (
        i_wr && i_addr == `SCCR_ADDR_CGEN_CFG |=> o_ctrl.ana_clk_en == $past(i_wdata[0]))
        else $error("analog clock enable did not follow write");
    chk_log_clk_wr: assert property (
        i_wr && i_addr == `SCCR_ADDR_CGEN_CFG |=> o_ctrl.log_clk_en == $past(i_wdata[1]))
        else $error("logic clock enable did not follow write");
    chk_src_sel_wr: assert property (
        i_wr && i_addr == `SCCR_ADDR_CGEN_CFG |=> o_ctrl.sel_synth == $past(i_wdata[2]))
        else $error("clock source select did not follow write");
    chk_adc_mode_rd: assert property (
        i_rd && i_addr == `SCCR_ADDR_CGEN_CFG && !i_wr |=> o_rdata[3] == o_ctrl.adc_8bit)
        else $error("resolution bit readback mismatch");
    chk_gen_en_hold: assert property (
        !(i_wr && i_addr == `SCCR_ADDR_GEN_CFG) |=> $stable(o_ctrl.gen_en))
        else $error("general enable changed without write");
    chk_core_pwr_wr: assert property (
        i_wr && i_addr == `SCCR_ADDR_CORE_CFG |=> o_ctrl.core_pwr == $past(i_wdata[0]))
        else $error("core power bit did not follow write");
    chk_mux_pwr_wr: assert property (
        i_wr && i_addr == `SCCR_ADDR_CORE_CFG |=> o_ctrl.mux_pwr == $past(i_wdata[1]))
        else $error("column mux power did not follow write");
    chk_colbias_wr: assert property (
        i_wr && i_addr == `SCCR_ADDR_CORE_CFG |=> o_ctrl.colbias_en == $past(i_wdata[2]))
        else $error("column bias enable did not follow write");
    chk_lock_rd: assert property (
        i_rd && i_addr == `SCCR_ADDR_LOCK_STS && $past(i_nrst, 2)
        |=> o_rdata == {15'h0000, $past(i_synth_lock, 3)})
        else $error("lock status readback mismatch");
    chk_bypass_wr: assert property (
        i_wr && i_addr == `SCCR_ADDR_SYN_PWR |=> o_ctrl.synth_bypass == $past(i_wdata[2]))
        else $error("synthesizer bypass did not follow write");

    chk_synth_run_wr: assert property (
        i_wr && i_addr == `SCCR_ADDR_SYN_PWR |=> o_ctrl.synth_run == $past(i_wdata[0]))
        else $error("synthesizer run bit did not follow write");
    chk_synth_en_wr: assert property (
        i_wr && i_addr == `SCCR_ADDR_SYN_PWR |=> o_ctrl.synth_en == $past(i_wdata[1]))
        else $error("synthesizer enable did not follow write");
    chk_adc_mode_wr: assert property (
        i_wr && i_addr == `SCCR_ADDR_CGEN_CFG |=> o_ctrl.adc_8bit == $past(i_wdata[3]))
        else $error("resolution bit did not follow write");
    chk_gen_en_wr: assert property (
        i_wr && i_addr == `SCCR_ADDR_GEN_CFG |=> o_ctrl.gen_en == $past(i_wdata[0]))
        else $error("general enable did not follow write");

    // a write keeps only the implemented bits
    chk_syn_pwr_land: assert property (
        i_wr && i_addr == `SCCR_ADDR_SYN_PWR
        |=> st.syn_pwr == ($past(i_wdata) & `SCCR_MASK_SYN_PWR))
        else $error("synthesizer power word did not land masked");
    chk_io_cfg_land: assert property (
        i_wr && i_addr == `SCCR_ADDR_IO_CFG
        |=> st.io_cfg == ($past(i_wdata) & `SCCR_MASK_IO_CFG))
        else $error("clock input word did not land masked");
    chk_rsv_a_land: assert property (
        i_wr && i_addr == `SCCR_ADDR_LOCK_RSV_A
        |=> st.rsv_a == ($past(i_wdata) & `SCCR_MASK_LOCK_RSV_A))
        else $error("first spare lock word did not land masked");
    chk_rsv_b_land: assert property (
        i_wr && i_addr == `SCCR_ADDR_LOCK_RSV_B
        |=> st.rsv_b == ($past(i_wdata) & `SCCR_MASK_LOCK_RSV_B))
        else $error("second spare lock word did not land masked");
    chk_cgen_cfg_land: assert property (
        i_wr && i_addr == `SCCR_ADDR_CGEN_CFG
        |=> st.cgen_cfg == ($past(i_wdata) & `SCCR_MASK_CGEN_CFG))
        else $error("clock generator word did not land masked");
    chk_gen_cfg_land: assert property (
        i_wr && i_addr == `SCCR_ADDR_GEN_CFG
        |=> st.gen_cfg == ($past(i_wdata) & `SCCR_MASK_GEN_CFG))
        else $error("general logic word did not land masked");
    chk_core_cfg_land: assert property (
        i_wr && i_addr == `SCCR_ADDR_CORE_CFG
        |=> st.core_cfg == ($past(i_wdata) & `SCCR_MASK_CORE_CFG))
        else $error("pixel core word did not land masked");

    // registers move only when written
    chk_syn_pwr_hold: assert property (
        !(i_wr && i_addr == `SCCR_ADDR_SYN_PWR) |=> $stable(st.syn_pwr))
        else $error("synthesizer power word changed without write");
    chk_io_cfg_hold: assert property (
        !(i_wr && i_addr == `SCCR_ADDR_IO_CFG) |=> $stable(st.io_cfg))
        else $error("clock input word changed without write");
    chk_rsv_a_hold: assert property (
        !(i_wr && i_addr == `SCCR_ADDR_LOCK_RSV_A) |=> $stable(st.rsv_a))
        else $error("first spare lock word changed without write");
    chk_rsv_b_hold: assert property (
        !(i_wr && i_addr == `SCCR_ADDR_LOCK_RSV_B) |=> $stable(st.rsv_b))
        else $error("second spare lock word changed without write");
    chk_cgen_cfg_hold: assert property (
        !(i_wr && i_addr == `SCCR_ADDR_CGEN_CFG) |=> $stable(st.cgen_cfg))
        else $error("clock generator word changed without write");
    chk_gen_cfg_hold: assert property (
        !(i_wr && i_addr == `SCCR_ADDR_GEN_CFG) |=> $stable(st.gen_cfg))
        else $error("general logic word changed without write");
    chk_core_cfg_hold: assert property (
        !(i_wr && i_addr == `SCCR_ADDR_CORE_CFG) |=> $stable(st.core_cfg))
        else $error("pixel core word changed without write");

    // write, one idle cycle, read of the same word
    chk_syn_pwr_echo: assert property (
        i_wr && i_addr == `SCCR_ADDR_SYN_PWR
        ##1 !i_wr ##1 i_rd && i_addr == `SCCR_ADDR_SYN_PWR
        |=> o_rdata == ($past(i_wdata, 3) & `SCCR_MASK_SYN_PWR))
        else $error("synthesizer power readback differs from write");
    chk_io_cfg_echo: assert property (
        i_wr && i_addr == `SCCR_ADDR_IO_CFG
        ##1 !i_wr ##1 i_rd && i_addr == `SCCR_ADDR_IO_CFG
        |=> o_rdata == ($past(i_wdata, 3) & `SCCR_MASK_IO_CFG))
        else $error("clock input readback differs from write");
    chk_rsv_a_echo: assert property (
        i_wr && i_addr == `SCCR_ADDR_LOCK_RSV_A
        ##1 !i_wr ##1 i_rd && i_addr == `SCCR_ADDR_LOCK_RSV_A
        |=> o_rdata == ($past(i_wdata, 3) & `SCCR_MASK_LOCK_RSV_A))
        else $error("first spare lock readback differs from write");
    chk_rsv_b_echo: assert property (
        i_wr && i_addr == `SCCR_ADDR_LOCK_RSV_B
        ##1 !i_wr ##1 i_rd && i_addr == `SCCR_ADDR_LOCK_RSV_B
        |=> o_rdata == ($past(i_wdata, 3) & `SCCR_MASK_LOCK_RSV_B))
        else $error("second spare lock readback differs from write");
    chk_cgen_cfg_echo: assert property (
        i_wr && i_addr == `SCCR_ADDR_CGEN_CFG
        ##1 !i_wr ##1 i_rd && i_addr == `SCCR_ADDR_CGEN_CFG
        |=> o_rdata == ($past(i_wdata, 3) & `SCCR_MASK_CGEN_CFG))
        else $error("clock generator readback differs from write");
    chk_gen_cfg_echo: assert property (
        i_wr && i_addr == `SCCR_ADDR_GEN_CFG
        ##1 !i_wr ##1 i_rd && i_addr == `SCCR_ADDR_GEN_CFG
        |=> o_rdata == ($past(i_wdata, 3) & `SCCR_MASK_GEN_CFG))
        else $error("general logic readback differs from write");
    chk_core_cfg_echo: assert property (
        i_wr && i_addr == `SCCR_ADDR_CORE_CFG
        ##1 !i_wr ##1 i_rd && i_addr == `SCCR_ADDR_CORE_CFG
        |=> o_rdata == ($past(i_wdata, 3) & `SCCR_MASK_CORE_CFG))
        else $error("pixel core readback differs from write");

    // unimplemented bits always read as zero
    chk_syn_pwr_spare: assert property (
        i_rd && i_addr == `SCCR_ADDR_SYN_PWR
        |=> (o_rdata & ~`SCCR_MASK_SYN_PWR) == 16'h0000)
        else $error("unimplemented synthesizer power bits read nonzero");
    chk_io_cfg_spare: assert property (
        i_rd && i_addr == `SCCR_ADDR_IO_CFG
        |=> (o_rdata & ~`SCCR_MASK_IO_CFG) == 16'h0000)
        else $error("unimplemented clock input bits read nonzero");
    chk_rsv_a_spare: assert property (
        i_rd && i_addr == `SCCR_ADDR_LOCK_RSV_A
        |=> (o_rdata & ~`SCCR_MASK_LOCK_RSV_A) == 16'h0000)
        else $error("unimplemented spare lock bits read nonzero");
    chk_cgen_cfg_spare: assert property (
        i_rd && i_addr == `SCCR_ADDR_CGEN_CFG
        |=> (o_rdata & ~`SCCR_MASK_CGEN_CFG) == 16'h0000)
        else $error("unimplemented clock generator bits read nonzero");
    chk_gen_cfg_spare: assert property (
        i_rd && i_addr == `SCCR_ADDR_GEN_CFG
        |=> (o_rdata & ~`SCCR_MASK_GEN_CFG) == 16'h0000)
        else $error("unimplemented general logic bits read nonzero");
    chk_core_cfg_spare: assert property (
        i_rd && i_addr == `SCCR_ADDR_CORE_CFG
        |=> (o_rdata & ~`SCCR_MASK_CORE_CFG) == 16'h0000)
        else $error("unimplemented pixel core bits read nonzero");

    // readback fields sit where the controls take them from
    chk_syn_pwr_view: assert property (
        i_rd && i_addr == `SCCR_ADDR_SYN_PWR && !i_wr
        |=> o_rdata[2:0] == {o_ctrl.synth_bypass, o_ctrl.synth_en, o_ctrl.synth_run})
        else $error("synthesizer power readback differs from controls");
    chk_io_cfg_view: assert property (
        i_rd && i_addr == `SCCR_ADDR_IO_CFG && !i_wr
        |=> o_rdata[0] == o_ctrl.clkin_pwr)
        else $error("clock input readback differs from control");
    chk_cgen_cfg_view: assert property (
        i_rd && i_addr == `SCCR_ADDR_CGEN_CFG && !i_wr
        |=> o_rdata[2:0] == {o_ctrl.sel_synth, o_ctrl.log_clk_en, o_ctrl.ana_clk_en})
        else $error("clock generator readback differs from controls");
    chk_gen_cfg_view: assert property (
        i_rd && i_addr == `SCCR_ADDR_GEN_CFG && !i_wr
        |=> o_rdata[0] == o_ctrl.gen_en)
        else $error("general logic readback differs from control");
    chk_core_cfg_view: assert property (
        i_rd && i_addr == `SCCR_ADDR_CORE_CFG && !i_wr
        |=> o_rdata[2:0] == {o_ctrl.colbias_en, o_ctrl.mux_pwr, o_ctrl.core_pwr})
        else $error("pixel core readback differs from controls");

    // every writable register side by side, for the stability checks
    logic [111:0] cfg_all;
    assign cfg_all = {st.syn_pwr, st.io_cfg, st.rsv_a, st.rsv_b,
                      st.cgen_cfg, st.gen_cfg, st.core_cfg};

    chk_rdata_idle: assert property (
        !i_rd |=> o_rdata == 16'h0000)
        else $error("read data not zero outside a read");
    chk_unmapped_rd: assert property (
        i_rd && !is_mapped(i_addr) |=> o_rdata == 16'h0000)
        else $error("unmapped read returned data");
    chk_unmapped_wr: assert property (
        i_wr && (!is_mapped(i_addr) || i_addr == `SCCR_ADDR_LOCK_STS)
        |=> $stable(cfg_all))
        else $error("refused write changed a register");
    chk_read_quiet: assert property (
        i_rd && !i_wr |=> $stable(cfg_all))
        else $error("read changed a register");
    chk_lock_sync: assert property (
        $past(i_nrst, 2) |-> st.lock_s == $past(i_synth_lock, 2))
        else $error("lock synchroniser latency wrong");

    cov_core_up: cover property (o_ctrl.core_pwr && o_ctrl.mux_pwr && o_ctrl.colbias_en);
    cov_clk_run: cover property (o_ctrl.ana_clk_en && o_ctrl.log_clk_en && !o_ctrl.sel_synth);
    cov_lock_rd: cover property (i_rd && i_addr == `SCCR_ADDR_LOCK_STS ##1 o_rdata[0]);
    cov_adc_8bit: cover property (i_wr && i_addr == `SCCR_ADDR_CGEN_CFG && i_wdata[3]
        ##1 o_ctrl.adc_8bit);
    cov_unmapped_rd: cover property (i_rd && !is_mapped(i_addr));

endmodule : sccr_regs

/* File: sccr_consts.svh */
// address map, field positions and reset values of the clock/core register bank
`ifndef SCCR_CONSTS_SVH
`define SCCR_CONSTS_SVH

`define SCCR_ADDR_SYN_PWR     9'h010
`define SCCR_ADDR_IO_CFG      9'h014
`define SCCR_ADDR_LOCK_STS    9'h018
`define SCCR_ADDR_LOCK_RSV_A  9'h01a
`define SCCR_ADDR_LOCK_RSV_B  9'h01b
`define SCCR_ADDR_CGEN_CFG    9'h020
`define SCCR_ADDR_GEN_CFG     9'h022
`define SCCR_ADDR_CORE_CFG    9'h028

`define SCCR_RST_SYN_PWR      16'h0004
`define SCCR_RST_IO_CFG       16'h0000
`define SCCR_RST_LOCK_RSV_A   16'h2182
`define SCCR_RST_LOCK_RSV_B   16'h3d2d
`define SCCR_RST_CGEN_CFG     16'h0004
`define SCCR_RST_GEN_CFG      16'h0000
`define SCCR_RST_CORE_CFG     16'h0000

`define SCCR_MASK_SYN_PWR     16'h0007
`define SCCR_MASK_IO_CFG      16'h0701
`define SCCR_MASK_LOCK_RSV_A  16'h7fff
`define SCCR_MASK_LOCK_RSV_B  16'hffff
`define SCCR_MASK_CGEN_CFG    16'h7f0f
`define SCCR_MASK_GEN_CFG     16'h0001
`define SCCR_MASK_CORE_CFG    16'h0007

`define SCCR_BIT_SYN_RUN      0
`define SCCR_BIT_SYN_EN       1
`define SCCR_BIT_SYN_BYPASS   2
`define SCCR_BIT_CLKIN_PWR    0
`define SCCR_BIT_LOCK         0
`define SCCR_BIT_ANA_CLK_EN   0
`define SCCR_BIT_LOG_CLK_EN   1
`define SCCR_BIT_SEL_SYNTH    2
`define SCCR_BIT_ADC_8BIT     3
`define SCCR_BIT_GEN_EN       0
`define SCCR_BIT_CORE_PWR     0
`define SCCR_BIT_MUX_PWR      1
`define SCCR_BIT_COLBIAS_EN   2

`endif

/* File: sccr_pkg.sv */
// types shared by the clock/core register bank
package sccr_pkg;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [8:0]  addr;
        logic [15:0] wdata;
    } sccr_req_t;

    typedef struct packed {
        logic synth_run;
        logic synth_en;
        logic synth_bypass;
        logic clkin_pwr;
        logic ana_clk_en;
        logic log_clk_en;
        logic sel_synth;
        logic adc_8bit;
        logic gen_en;
        logic core_pwr;
        logic mux_pwr;
        logic colbias_en;
    } sccr_ctrl_t;

    typedef struct packed {
        logic [15:0] syn_pwr;
        logic [15:0] io_cfg;
        logic [15:0] rsv_a;
        logic [15:0] rsv_b;
        logic [15:0] cgen_cfg;
        logic [15:0] gen_cfg;
        logic [15:0] core_cfg;
        logic [15:0] rdata;
        logic        lock_m;
        logic        lock_s;
    } sccr_state_t;

endpackage : sccr_pkg

/* File: sccr_host.sv */
// bus master model issuing one-cycle register writes and reads
module sccr_host
    import sccr_pkg::*;
(
    input  wire logic        i_mclk,
    input  wire logic [15:0] i_rdata,
    output logic             o_wr,
    output logic             o_rd,
    output logic      [8:0]  o_addr,
    output logic      [15:0] o_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = 9'h000;
        o_wdata = 16'h0000;
    end
    // idle bus shows the inverse of the last value
    task automatic wr(input logic [8:0] a, input logic [15:0] d);
        @(posedge i_mclk);
        o_wr <= 1'b1;
        o_addr <= a;
        o_wdata <= d;
        @(posedge i_mclk);
        o_wr <= 1'b0;
        o_addr <= ~a;
        o_wdata <= ~d;
    endtask : wr
    task automatic rd(input logic [8:0] a, output logic [15:0] d);
        @(posedge i_mclk);
        o_rd <= 1'b1;
        o_addr <= a;
        @(posedge i_mclk);
        o_rd <= 1'b0;
        o_addr <= ~a;
        @(posedge i_mclk);
        d = i_rdata;
    endtask : rd
endmodule : sccr_host

/* File: test_sccr_regs.sv */
// self-checking bench for the clock/core register bank
`include "sccr_consts.svh"
module test_sccr_regs
    import sccr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk = 1'b0;
    logic        nrst = 1'b0;
    logic        lock = 1'b0;
    logic        wr;
    logic        rd;
    logic [8:0]  addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic [15:0] d;
    sccr_ctrl_t  ctrl;
    sccr_ctrl_t  exp;
    int          err_count = 0;
    int          checks = 0;
    logic [8:0]  ra[7] = '{9'h010, 9'h014, 9'h01a, 9'h01b, 9'h020, 9'h022, 9'h028};
    logic [15:0] rv[7] = '{16'h0004, 16'h0000, 16'h2182, 16'h3d2d, 16'h0004, 16'h0000, 16'h0000};
    logic [15:0] mk[7] = '{16'h0007, 16'h0701, 16'h7fff, 16'hffff, 16'h7f0f, 16'h0001, 16'h0007};
    // owning register and bit of each control field, msb first
    logic [8:0]  fa[12] = '{9'h010, 9'h010, 9'h010, 9'h014, 9'h020, 9'h020, 9'h020, 9'h020,
                            9'h022, 9'h028, 9'h028, 9'h028};
    int          fb[12] = '{0, 1, 2, 0, 0, 1, 2, 3, 0, 0, 1, 2};
    always #2 mclk = ~mclk;
    sccr_regs sccr_regs_i (.i_mclk(mclk), .i_nrst(nrst), .i_wr(wr), .i_rd(rd), .i_addr(addr),
        .i_wdata(wdata), .i_synth_lock(lock), .o_rdata(rdata), .o_ctrl(ctrl));
    sccr_host sccr_host_i (.i_mclk(mclk), .i_rdata(rdata), .o_wr(wr), .o_rd(rd),
        .o_addr(addr), .o_wdata(wdata));
    task automatic cmp_word(input logic [15:0] got, input logic [15:0] want);
        checks++;
        if (got !== want) begin
            err_count++;
            $display("Error at %0t: read %h, expected %h", $time, got, want);
        end
    endtask : cmp_word
    task automatic cmp_ctrl(input sccr_ctrl_t want);
        #1;
        checks++;
        if (ctrl !== want) begin
            err_count++;
            $display("Error at %0t: controls %h, expected %h", $time, ctrl, want);
        end
    endtask : cmp_ctrl
    task automatic print_verdict();
        $display("errors %0d, checks %0d", err_count, checks);
        if (err_count == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : print_verdict
    task automatic chk_defaults();
        exp = '0;
        exp.synth_bypass = 1'b1;
        exp.sel_synth = 1'b1;
        cmp_ctrl(exp);
        for (int i = 0; i < 7; i++) begin
            sccr_host_i.rd(ra[i], d);
            cmp_word(d, rv[i]);
        end
    endtask : chk_defaults
    initial begin
        repeat (20000) @(posedge mclk);
        err_count++;
        print_verdict();
    end
    initial begin
        repeat (5) @(posedge mclk);
        nrst <= 1'b1;
        chk_defaults();
        for (int i = 0; i < 7; i++) begin
            sccr_host_i.wr(ra[i], 16'hffff);
            sccr_host_i.rd(ra[i], d);
            cmp_word(d, mk[i]);
        end
        cmp_ctrl('1);
        for (int i = 0; i < 7; i++) begin
            sccr_host_i.wr(ra[i], 16'h0000);
        end
        cmp_ctrl('0);
        // each field alone, so a swapped bit shows
        for (int i = 0; i < 12; i++) begin
            sccr_host_i.wr(fa[i], 16'h0001 << fb[i]);
            cmp_ctrl(sccr_ctrl_t'(12'h800 >> i));
            sccr_host_i.wr(fa[i], 16'h0000);
        end
        sccr_host_i.wr(9'h018, 16'hffff);
        sccr_host_i.rd(9'h018, d);
        cmp_word(d, 16'h0000);
        lock <= 1'b1;
        sccr_host_i.rd(9'h018, d);
        sccr_host_i.rd(9'h018, d);
        cmp_word(d, 16'h0001);
        lock <= 1'b0;
        sccr_host_i.rd(9'h018, d);
        sccr_host_i.rd(9'h018, d);
        cmp_word(d, 16'h0000);
        sccr_host_i.wr(9'h01c, 16'hffff);
        sccr_host_i.rd(9'h01c, d);
        cmp_word(d, 16'h0000);
        sccr_host_i.wr(9'h020, 16'hffff);
        @(posedge mclk);
        nrst <= 1'b0;
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        chk_defaults();
        print_verdict();
    end
endmodule : test_sccr_regs
